// ---- lst_pkg.sv ----
// Constants and carrier types for the LCD sync timing and dot clock block
package lst_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SYNCW  = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_HACT   = 8'h0c;
  localparam logic [7:0] OFS_VACT   = 8'h10;
  localparam logic [7:0] OFS_VACTE  = 8'h14;
  localparam logic [7:0] OFS_ODLY   = 8'h18;
  localparam logic [7:0] OFS_HMASK  = 8'h1c;
  localparam logic [7:0] OFS_MASKR  = 8'h20;
  localparam logic [7:0] OFS_PAT    = 8'h24;
  localparam logic [7:0] OFS_PATEND = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;

  // Field positions shared by all two-field registers
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int TW     = 12;

  localparam logic [31:0] CTRL_RST = 32'h003f_0001;

  // Standard timing figures
  localparam logic [11:0] SD_HSYNC     = 12'h07f;
  localparam logic [11:0] HD_HSYNC     = 12'h03f;
  localparam logic [11:0] NTSC_LINE    = 12'h6b4;
  localparam logic [11:0] PAL_LINE     = 12'h6bc;
  localparam logic [11:0] HD0_LINE     = 12'h35a;
  localparam logic [11:0] HD1_LINE     = 12'h360;
  localparam logic [11:0] HD2_LINE     = 12'h898;
  localparam logic [11:0] HD3_LINE     = 12'h672;
  // Vertical figures in half lines; the sync widths count lines in HD
  localparam logic [11:0] NTSC_FIELD_H = 12'h20d;
  localparam logic [11:0] PAL_FIELD_H  = 12'h271;
  localparam logic [11:0] HD0_FRAME_H  = 12'h41a;
  localparam logic [11:0] HD1_FRAME_H  = 12'h4e2;
  localparam logic [11:0] HD2_FRAME_H  = 12'h465;
  localparam logic [11:0] HD3_FRAME_H  = 12'h5dc;
  localparam logic [11:0] VSW_SIX      = 12'h006;
  localparam logic [11:0] VSW_FIVE     = 12'h005;

  localparam logic [4:0] SLAVE_HS_LAT = 5'h13;

  // Field detect methods
  localparam logic [1:0] FD_LATCH = 2'h0;
  localparam logic [1:0] FD_RAW   = 2'h1;
  localparam logic [1:0] FD_VSYNC = 2'h2;
  localparam logic [1:0] FD_PHASE = 2'h3;

  typedef struct packed {
    logic [9:0] rsvd;
    logic [5:0] pattern_length;
    logic       spare;
    logic       h_mask_sel;
    logic       line_pattern_switch;
    logic       clock_mask_enable;
    logic       pattern_type;
    logic [1:0] field_detect_method;
    logic       slave_mode;
    logic       even_length_enable;
    logic       even_start_enable;
    logic       sync_width_override;
    logic [1:0] standard_select;
    logic       definition_select;
    logic       nonstd_interlace;
    logic       timing_mode;
  } lst_ctrl_s;

  typedef struct packed {
    logic hs;
    logic vs;
    logic fd;
  } lst_sync_s;

endpackage : lst_pkg

// ---- lst_timing.sv ----
// LCD sync timing generator and dot clock generator with AHB-Lite registers
// Notes on behaviour
// - Non-standard interlace counts vertical interval and sync in half lines.
// - Line period is interval plus one clock; frame is interval plus one.
// - Sync widths and active windows come from programmable registers.
// - Odd fields use primary vertical values; even fields use alternates if enabled.
// - Output syncs delayed by own counts; field follows vertical; internal unshifted.
// - Standard timing mode fixes widths and intervals, ignoring registers.
// - Width override takes standard sync widths from registers, intervals kept.
// - SD standard: 127-clock hsync, 1716/1724 lines, 262.5/312.5, vsync 6/5.
// - HD standard: 63-clock hsync, lines 858/864/2200/1650 with frame periods.
// - SD interlaced vertical sync width counts in half lines.
// - Slave internal hsync asserts 19 clocks after latched external hsync.
// - NTSC/PAL slave resets vertical at hsync start or at mid-line.
// - Vertical sync after hsync assertion waits for next hsync start.
// - Non-standard interlace slave resets vertical only at hsync start.
// - PAL slave field identity has polarity opposite to NTSC.
// - Slave field from latched field, raw field, vsync, or vsync phase.
// - Phase method: vsync in first half is even, second half odd.
// - Phase method in non-standard modes always reports odd.
// - Dot clock drives the video clock pin; pixel data follows its rise in type 0, every enable in type 1.
// - Dot clock from 64-bit pattern, programmable length, alternate set.
// - Pattern type 0 gives levels; type 1 gives encoder clock enables.
// - Masking gates the dot clock outside a horizontal and vertical window.
// - Line pattern switch picks primary or alternate by culled line ID.
// - Field signal high means odd field.
`timescale 1ns/100ps
module lst_timing #(
  parameter int DLY_W = 6
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // External sync source, asynchronous pins
  input  wire lst_pkg::lst_sync_s    sync_in,
  // Line control and pixel source
  input  wire logic                  culled_line_id,
  input  wire logic [23:0]           pix_in,
  // Panel side
  output logic                       hsync_out,
  output logic                       vsync_out,
  output logic                       field_out,
  output logic                       data_valid_out,
  output logic                       hsync_int,
  output logic                       video_clock_pin,
  output logic                       dot_clock_en,
  output logic [23:0]                pix_out
);

  localparam int DEPTH = 1 << DLY_W;

  if (DLY_W < 1 || DLY_W > 8) begin : g_chk
    $error("lst_timing: DLY_W must be 1 to 8");
  end

  typedef logic [11:0] lst_t;

  typedef struct packed {
    lst_pkg::lst_ctrl_s     ctrl;
    lst_t                   hsw, vsw, lper, fper, has, hal;
    lst_t                   vas, val, vase, vale, hms, hmsa, hmr, vms;
    logic [DLY_W-1:0]       hdly, vdly;
    logic [1:0][3:0][15:0]  pat;
    logic                   ap_v, ap_w;
    logic [7:0]             ap_a;
    logic [31:0]            rdata;
    lst_pkg::lst_sync_s     s1, s2, s3, sf;
    logic [4:0]             slv_cnt;
    logic                   vpend, fd_lat, fd_ph;
    lst_t                   h, vh;
    logic                   field;
    logic [5:0]             ptr;
    logic [DEPTH-1:0]       hs_sr, vs_sr, fd_sr;
    logic                   hs_o, vs_o, fd_o, de_o, dot_clock, en;
    logic [23:0]            pix;
  } lst_state_s;

  lst_state_s s;
  lst_state_s n;

  function automatic lst_t std_line(input logic sd, input logic [1:0] sel);
    if (sd) begin
      std_line = sel[0] ? lst_pkg::PAL_LINE : lst_pkg::NTSC_LINE;
    end else begin
      case (sel)
        2'h0:    std_line = lst_pkg::HD0_LINE;
        2'h1:    std_line = lst_pkg::HD1_LINE;
        2'h2:    std_line = lst_pkg::HD2_LINE;
        default: std_line = lst_pkg::HD3_LINE;
      endcase
    end
  endfunction : std_line

  function automatic lst_t std_vhalf(input logic sd, input logic [1:0] sel);
    if (sd) begin
      std_vhalf = sel[0] ? lst_pkg::PAL_FIELD_H : lst_pkg::NTSC_FIELD_H;
    end else begin
      case (sel)
        2'h0:    std_vhalf = lst_pkg::HD0_FRAME_H;
        2'h1:    std_vhalf = lst_pkg::HD1_FRAME_H;
        2'h2:    std_vhalf = lst_pkg::HD2_FRAME_H;
        default: std_vhalf = lst_pkg::HD3_FRAME_H;
      endcase
    end
  endfunction : std_vhalf

  function automatic logic in_win(input lst_t v, input lst_t st,
                                  input lst_t len);
    in_win = (v >= st) && ({1'b0, v} < ({1'b0, st} + {1'b0, len}));
  endfunction : in_win

  // Derived timing
  logic       std, sd, pal, ilace, even, hwrap, midline, vreset;
  logic       hs_i, vs_i, de_i, vs_rise, hs_rise, fd_det, pbit, gate;
  lst_t       hmax, half, vmax, hsw_e, vsw_e, vst, vln, line, hmst;
  logic [2:0] pidx;
  logic [7:0] woff, roff;

  always_comb begin
    std   = !s.ctrl.timing_mode;
    sd    = !s.ctrl.definition_select;
    pal   = std && sd && s.ctrl.standard_select[0];
    ilace = std ? sd : s.ctrl.nonstd_interlace;
    hmax  = std ? std_line(sd, s.ctrl.standard_select) - 12'h001
                : s.lper;
    half  = 12'((13'(hmax) + 13'h0001) >> 1);
    if (std) begin
      vmax = std_vhalf(sd, s.ctrl.standard_select) - 12'h001;
    end else if (s.ctrl.nonstd_interlace) begin
      vmax = s.fper;
    end else begin
      vmax = 12'({s.fper, 1'b1});
    end
    if (std && !s.ctrl.sync_width_override) begin
      hsw_e = sd ? lst_pkg::SD_HSYNC : lst_pkg::HD_HSYNC;
      vsw_e = (s.ctrl.standard_select == 2'h0) ? lst_pkg::VSW_SIX
                                               : lst_pkg::VSW_FIVE;
      if (!sd) begin
        vsw_e = 12'({vsw_e, 1'b0});
      end
    end else begin
      hsw_e = s.hsw;
      vsw_e = ilace ? s.vsw : 12'({s.vsw, 1'b0});
    end
    line  = {1'b0, s.vh[11:1]};
    even  = ilace && !s.field;
    vst   = (even && s.ctrl.even_start_enable) ? s.vase : s.vas;
    vln   = (even && s.ctrl.even_length_enable) ? s.vale : s.val;
    hs_i  = s.h < hsw_e;
    vs_i  = s.vh < vsw_e;
    de_i  = in_win(s.h, s.has, s.hal) && in_win(line, vst, vln);
    hs_rise = s.s3.hs && (s.s2.hs == s.s3.hs) && !s.sf.hs;
    vs_rise = s.s3.vs && (s.s2.vs == s.s3.vs) && !s.sf.vs;
    hwrap   = s.ctrl.slave_mode ? (s.slv_cnt == 5'h01) || (s.h == hmax)
                                : (s.h == hmax);
    midline = (s.h == half - 12'h001);
    // Mid-line resync only for NTSC/PAL, pending reset otherwise waits
    vreset  = s.ctrl.slave_mode && s.vpend &&
              (hwrap || (midline && std && sd));
    case (s.ctrl.field_detect_method)
      lst_pkg::FD_LATCH: fd_det = s.fd_lat;
      lst_pkg::FD_RAW:   fd_det = s.sf.fd;
      lst_pkg::FD_VSYNC: fd_det = s.sf.vs;
      default:           fd_det = s.fd_ph;
    endcase
    fd_det = fd_det ^ pal;
    pidx  = {s.ctrl.line_pattern_switch & culled_line_id, s.ptr[5:4]};
    pbit  = s.pat[pidx[2]][pidx[1:0]][s.ptr[3:0]];
    hmst  = s.ctrl.h_mask_sel ? s.hmsa : s.hms;
    gate  = !s.ctrl.clock_mask_enable ||
            (in_win(s.h, hmst, s.hmr) && (line >= s.vms));
    woff  = s.ap_a - lst_pkg::OFS_PAT;
    roff  = haddr[7:0] - lst_pkg::OFS_PAT;
  end

  always_comb begin
    n = s;
    // Bus address phase, read data registered for the data phase
    n.ap_v = hsel && hready && htrans[1];
    n.ap_w = hwrite;
    n.ap_a = {haddr[7:2], 2'b00};
    if (hsel && hready && htrans[1] && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        lst_pkg::OFS_CTRL:   n.rdata = s.ctrl;
        lst_pkg::OFS_SYNCW:  n.rdata = {4'h0, s.vsw, 4'h0, s.hsw};
        lst_pkg::OFS_PERIOD: n.rdata = {4'h0, s.fper, 4'h0, s.lper};
        lst_pkg::OFS_HACT:   n.rdata = {4'h0, s.hal, 4'h0, s.has};
        lst_pkg::OFS_VACT:   n.rdata = {4'h0, s.val, 4'h0, s.vas};
        lst_pkg::OFS_VACTE:  n.rdata = {4'h0, s.vale, 4'h0, s.vase};
        lst_pkg::OFS_ODLY:   n.rdata = {16'(s.vdly), 16'(s.hdly)};
        lst_pkg::OFS_HMASK:  n.rdata = {4'h0, s.hmsa, 4'h0, s.hms};
        lst_pkg::OFS_MASKR:  n.rdata = {4'h0, s.vms, 4'h0, s.hmr};
        lst_pkg::OFS_STATUS: n.rdata = {15'h0000, s.field, 4'h0, s.vh};
        default: begin
          if (haddr[7:0] >= lst_pkg::OFS_PAT &&
              haddr[7:0] <= lst_pkg::OFS_PATEND) begin
            // Read index comes from the live address, not the write latch
            n.rdata = {16'h0000, s.pat[roff[4]][roff[3:2]]};
          end else begin
            n.rdata = 32'h0000_0000;
          end
        end
      endcase
    end
    if (s.ap_v && s.ap_w) begin
      case (s.ap_a)
        lst_pkg::OFS_CTRL:   n.ctrl = lst_pkg::lst_ctrl_s'({10'h000,
                                                 hwdata[21:0]});
        lst_pkg::OFS_SYNCW:  {n.vsw, n.hsw} = {hwdata[27:16], hwdata[11:0]};
        lst_pkg::OFS_PERIOD: {n.fper, n.lper} = {hwdata[27:16], hwdata[11:0]};
        lst_pkg::OFS_HACT:   {n.hal, n.has} = {hwdata[27:16], hwdata[11:0]};
        lst_pkg::OFS_VACT:   {n.val, n.vas} = {hwdata[27:16], hwdata[11:0]};
        lst_pkg::OFS_VACTE:  {n.vale, n.vase} = {hwdata[27:16], hwdata[11:0]};
        lst_pkg::OFS_ODLY: begin
          n.hdly = hwdata[DLY_W-1:0];
          n.vdly = hwdata[16+DLY_W-1:16];
        end
        lst_pkg::OFS_HMASK:  {n.hmsa, n.hms} = {hwdata[27:16], hwdata[11:0]};
        lst_pkg::OFS_MASKR:  {n.vms, n.hmr} = {hwdata[27:16], hwdata[11:0]};
        default: begin
          if (s.ap_a >= lst_pkg::OFS_PAT && s.ap_a <= lst_pkg::OFS_PATEND) begin
            n.pat[woff[4]][woff[3:2]] = hwdata[15:0];
          end
        end
      endcase
    end
    // Pin synchronisers; a change counts once stages two and three agree
    n.s1 = sync_in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.sf = s.s3;
    end
    // Horizontal counter
    n.slv_cnt = (s.slv_cnt != 5'h00) ? s.slv_cnt - 5'h01 : 5'h00;
    if (s.ctrl.slave_mode && hs_rise) begin
      n.slv_cnt = lst_pkg::SLAVE_HS_LAT;
    end
    n.h = hwrap ? 12'h000 : s.h + 12'h001;
    // Vertical counter in half lines
    if (hwrap || midline) begin
      if (s.vh == vmax) begin
        n.vh = 12'h000;
        n.field = ilace ? !s.field : 1'b0;
      end else begin
        n.vh = s.vh + 12'h001;
      end
    end
    if (s.ctrl.slave_mode && vs_rise) begin
      n.vpend  = 1'b1;
      n.fd_lat = s.sf.fd;
      n.fd_ph  = !(std && sd) || (s.h >= half);
    end
    if (vreset) begin
      n.vpend = 1'b0;
      n.vh    = 12'h000;
      n.field = ilace ? fd_det : 1'b0;
    end
    // Delayed sync outputs, internal timing untouched
    n.hs_sr = {s.hs_sr[DEPTH-2:0], hs_i};
    n.vs_sr = {s.vs_sr[DEPTH-2:0], vs_i};
    n.fd_sr = {s.fd_sr[DEPTH-2:0], s.field};
    n.hs_o  = n.hs_sr[s.hdly];
    n.vs_o  = n.vs_sr[s.vdly];
    n.fd_o  = n.fd_sr[s.vdly];
    n.de_o  = de_i;
    // Dot clock pattern, pointer restarts on each line
    n.ptr = (hwrap || s.ptr == s.ctrl.pattern_length) ? 6'h00
                                                       : s.ptr + 6'h01;
    if (!s.ctrl.pattern_type) begin
      n.dot_clock = pbit & gate;
      n.en   = (pbit & gate) & !s.dot_clock;
    end else begin
      n.dot_clock = pbit & gate;
      n.en   = pbit & gate;
    end
    // Data changes with the dot clock rise in type 0, on every enabled clock in type 1
    if (n.en) begin
      n.pix = pix_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s      <= '0;
      s.ctrl <= lst_pkg::CTRL_RST;
    end else begin
      s <= n;
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = s.rdata;
  assign hsync_out       = s.hs_o;
  assign vsync_out       = s.vs_o;
  assign field_out       = s.fd_o;
  assign data_valid_out  = s.de_o;
  assign hsync_int       = hs_i;
  assign video_clock_pin = s.dot_clock;
  assign dot_clock_en    = s.en;
  assign pix_out         = s.pix;

endmodule : lst_timing

// ---- lst_timing_chk_sva.sv ----
// Port-level assertions for the LCD sync timing block
`timescale 1ns/100ps
module lst_timing_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Panel side
  input wire logic [23:0] pix_in,
  input wire logic [23:0] pix_out,
  input wire logic        hsync_int,
  input wire logic        hsync_out,
  input wire logic        vsync_out,
  input wire logic        field_out,
  input wire logic        data_valid_out,
  input wire logic        video_clock_pin,
  input wire logic        dot_clock_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_take = hsel && hready && htrans[1] && !hwrite;

  zero_wait_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (!hresp)
    else $error("slave gave an error response");
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  reset_quiet_a: assert property ($rose(hresetn) |->
    !hsync_out && !vsync_out && !field_out && !data_valid_out
    && !video_clock_pin) else $error("output active out of reset");
  hs_rise_a: assert property ($rose(hsync_int) |->
    ##[1:64] $rose(hsync_out)) else $error("hsync out rise missing");
  hs_fall_a: assert property ($fell(hsync_int) |->
    ##[1:64] $fell(hsync_out)) else $error("hsync out fall missing");
  pix_load_a: assert property ($rose(dot_clock_en) |->
    pix_out == $past(pix_in)) else $error("pixel not taken on dot rise");
  pix_hold_a: assert property (!dot_clock_en |->
    $stable(pix_out)) else $error("pixel moved without dot enable");

  cover property ($rose(vsync_out));
  cover property ($rose(hsync_out));
  cover property ($rose(dot_clock_en));
endmodule : lst_timing_chk

bind lst_timing lst_timing_chk u_lst_timing_chk (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .pix_in, .pix_out,
  .hsync_int, .hsync_out, .vsync_out, .field_out, .data_valid_out,
  .video_clock_pin, .dot_clock_en);

// ---- lst_sync_src.sv ----
// External sync source that drives the slave-mode sync pins
`timescale 1ns/100ps
module lst_sync_src #(
  parameter int LINE  = 12,
  parameter int FRAME = 10
) (
  // Link clock and enable
  input  wire logic          lclk,
  input  wire logic          run,
  // Sync pins toward the block
  output lst_pkg::lst_sync_s sync
);
  int h = 0;
  int v = 0;
  initial sync = '0;
  always @(posedge lclk) begin
    if (!run) begin
      sync <= '0;
    end else begin
      h <= (h == LINE - 1) ? 0 : h + 1;
      if (h == LINE - 1) begin
        v <= (v == FRAME - 1) ? 0 : v + 1;
      end
      sync.hs <= (h < 2);
      // Vertical rises together with horizontal, the safe case for locking
      sync.vs <= (v < 2) && (h < 2 || v == 1);
      if (h == LINE - 1 && v == FRAME - 1) begin
        sync.fd <= ~sync.fd;
      end
    end
  end
endmodule : lst_sync_src

// ---- testbench.sv ----
// Self-checking bench for the LCD sync timing block
`timescale 1ns/100ps
module testbench;
  logic        hclk = 1'b0, hresetn = 1'b0, lclk = 1'b0, run = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, culled_line_id = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [23:0] pix_in = '0;
  logic [31:0] hrdata;
  logic [23:0] pix_out;
  logic        hready, hreadyout, hresp, hsync_out, vsync_out, field_out;
  logic        data_valid_out, hsync_int, video_clock_pin, dot_clock_en;
  lst_pkg::lst_sync_s sync_in;
  int          num_errors = 0, num_checks = 0, cyc = 0;
  wire logic [5:0] obs = {video_clock_pin, dot_clock_en, data_valid_out,
                          vsync_out, hsync_out, hsync_int};

  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  // Link clock is offset by half a bus period so pin edges fall on hclk falling edges, never on rising ones
  always #80 lclk = ~lclk;
  always @(posedge hclk) cyc <= cyc + 1;
  always @(posedge hclk) pix_in <= pix_in + 24'h000001;

  lst_timing u_lst_timing (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .sync_in,
    .culled_line_id, .pix_in, .hsync_out, .vsync_out, .field_out,
    .data_valid_out, .hsync_int, .video_clock_pin, .dot_clock_en, .pix_out);
  lst_sync_src u_lst_sync_src (.lclk, .run, .sync(sync_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdc

  task automatic till(input int b, input logic v);
    do @(posedge hclk); while (obs[b] !== v);
  endtask : till

  task automatic rise(input int b);
    till(b, 1'b0);
    till(b, 1'b1);
  endtask : rise

  // Period and high time of one observed output, in clocks
  task automatic hv(input int b, p, w);
    int t, f;
    rise(b);
    t = cyc;
    till(b, 1'b0);
    f = cyc;
    till(b, 1'b1);
    chk(f - t, w);
    chk(cyc - t, p);
  endtask : hv

  task automatic ones(input int b, n, e);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge hclk);
      c += (obs[b] === 1'b1);
    end
    chk(c, e);
  endtask : ones

  task automatic dot(input int c, sk, b, n, e);
    wr(lst_pkg::OFS_CTRL, c);
    rise(0);
    repeat (sk) @(posedge hclk);
    ones(b, n, e);
  endtask : dot

  task automatic t_regs();
    rdc(lst_pkg::OFS_CTRL, lst_pkg::CTRL_RST);
    rdc(lst_pkg::OFS_SYNCW, 32'h0);
    rdc(8'h48, 32'h0);
    wr(lst_pkg::OFS_HMASK, 32'h0abc_0123);
    rdc(lst_pkg::OFS_HMASK, 32'h0abc_0123);
  endtask : t_regs

  task automatic t_prog();
    int   t;
    logic f;
    wr(lst_pkg::OFS_ODLY, 32'h0003_000a);
    wr(lst_pkg::OFS_PERIOD, 32'h0009_0063);
    wr(lst_pkg::OFS_HACT, 32'h001e_000a);
    wr(lst_pkg::OFS_VACT, 32'h0005_0001);
    wr(lst_pkg::OFS_SYNCW, 32'h0002_0005);
    hv(0, 100, 5);
    rise(0);
    t = cyc;
    till(1, 1'b1);
    chk(cyc - t, 11);
    hv(2, 1000, 200);
    rise(2);
    ones(3, 1000, 150);
    // Switch right after a frame start so the half-line count stays in range
    wr(lst_pkg::OFS_PERIOD, 32'h0014_0063);
    rise(2);
    wr(lst_pkg::OFS_CTRL, 32'h003f_0003);
    hv(2, 1050, 100);
    rise(2);
    f = field_out;
    rise(2);
    chk(field_out, !f);
  endtask : t_prog

  task automatic t_std();
    int ctl[6] = '{32'h003f_0000, 32'h003f_0008, 32'h003f_0004,
                   32'h003f_000c, 32'h003f_0014, 32'h003f_001c};
    int ln[6] = '{1716, 1724, 858, 864, 2200, 1650};
    for (int i = 0; i < 6; i++) begin
      wr(lst_pkg::OFS_CTRL, ctl[i]);
      rise(0);
      hv(0, ln[i], (i < 2) ? 127 : 63);
    end
    wr(lst_pkg::OFS_CTRL, 32'h003f_0020);
    rise(0);
    hv(0, 1716, 5);
  endtask : t_std

  task automatic t_dot();
    wr(lst_pkg::OFS_PERIOD, 32'h0009_03e7);
    wr(lst_pkg::OFS_PAT, 32'h0003);
    wr(8'h34, 32'h000f);
    rdc(8'h34, 32'h0000_000f);
    wr(lst_pkg::OFS_HMASK, 32'h0000_00c8);
    wr(lst_pkg::OFS_MASKR, 32'h0000_0032);
    dot(32'h0003_0001, 100, 5, 16, 8);
    dot(32'h0003_0001, 100, 4, 16, 4);
    dot(32'h0004_0001, 100, 5, 20, 8);
    dot(32'h0003_0801, 100, 4, 16, 8);
    culled_line_id <= 1'b1;
    dot(32'h0003_2001, 100, 5, 16, 16);
    culled_line_id <= 1'b0;
    dot(32'h0003_2001, 100, 5, 16, 8);
    dot(32'h0003_1001, 100, 5, 16, 0);
    dot(32'h0003_1001, 215, 5, 16, 8);
  endtask : t_dot

  task automatic t_slave();
    int n;
    wr(lst_pkg::OFS_SYNCW, 32'h0002_0004);
    wr(lst_pkg::OFS_CTRL, 32'h003f_0101);
    run <= 1'b1;
    @(posedge sync_in.hs);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hsync_int !== 1'b1 && n < 60);
    chk(n > 20 && n < 26, 1'b1);
    hv(0, 96, 4);
  endtask : t_slave

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_prog();
    t_std();
    t_dot();
    t_slave();
    end_sim();
  end

  // Expected run is near 51k clocks; this cuts off a hung wait
  initial begin
    #1_800_000;
    num_errors++;
    end_sim();
  end
endmodule : testbench
